// ### rtl/pfi_filter.sv
// pfi_filter: three-sample majority-free noise filter for one interrupt input
// assumes din is already synchronised to ref_clk
`timescale 1ns/10ps
module pfi_filter (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic din,
   input wire logic en,
   input wire logic [1:0] fclk,
   output logic dout
);
   logic [pfi_pkg::FLT_CNT_W-1:0] cnt_reg, cnt_next;
   logic [pfi_pkg::FLT_SAMPLES-2:0] samp_reg, samp_next;
   logic out_reg, out_next;
   logic [pfi_pkg::FLT_CNT_W-1:0] mask;
   logic tick;

   // ----------------------------------------
   // sample rate
   // ----------------------------------------
   // one free counter, masked per rate, so a rate change needs no reload
   always_comb begin
      case (fclk)
         2'h0: mask = pfi_pkg::FLT_CNT_W'(pfi_pkg::FLT_DIV1 - 1);
         2'h1: mask = pfi_pkg::FLT_CNT_W'(pfi_pkg::FLT_DIV8 - 1);
         2'h2: mask = pfi_pkg::FLT_CNT_W'(pfi_pkg::FLT_DIV32 - 1);
         default: mask = pfi_pkg::FLT_CNT_W'(pfi_pkg::FLT_DIV64 - 1);
      endcase
      tick = (cnt_reg & mask) == '0; // [R13] [R17]
   end

   // ----------------------------------------
   // filter state
   // ----------------------------------------
   // level moves only when three samples in a row agree
   always_comb begin
      cnt_next = cnt_reg + 1'b1;
      samp_next = samp_reg;
      out_next = out_reg;
      if (tick) begin
         samp_next = {samp_reg[0], din};
         if (din == samp_reg[0] && din == samp_reg[1]) begin
            out_next = din; // [R14] [R21]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         samp_reg <= 2'h3;
         out_reg <= 1'b1;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         samp_reg <= samp_next;
         out_reg <= out_next;
      end
   end

   // bypass when disabled; filtered path lags by the filter time
   assign dout = en ? out_reg : din; // [R15] [R16]
endmodule

// ### rtl/pfi_pkg.sv
// pfi_pkg: constants, register map and carriers for the pin function / irq filter block
// assumes a 32-bit classic wishbone slave and a single 125 MHz peripheral clock
package pfi_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NIRQ = 4;
   localparam int NPINS = 2 * NIRQ; // pins 0..3 normal irq pins, 4..7 deep-standby wake pins
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int PFS_W = 10;
   localparam int ICR_W = 5;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADR_WPR = 8'h00;
   localparam logic [7:0] ADR_LEVEL = 8'h04;
   localparam logic [7:0] ADR_PIN_IN = 8'h08;
   localparam logic [7:0] ADR_ICR_BASE = 8'h20;
   localparam logic [7:0] ADR_PFS_BASE = 8'h40;
   localparam int WPR_WE_BIT = 0;

   // ----------------------------------------
   // trigger modes and filter rates
   // ----------------------------------------
   typedef enum logic [1:0] {
      PFI_TRIG_LOW = 2'h0,
      PFI_TRIG_FALL = 2'h1,
      PFI_TRIG_RISE = 2'h2,
      PFI_TRIG_BOTH = 2'h3
   } pfi_trig_t;
   localparam int FLT_DIV1 = 1;
   localparam int FLT_DIV8 = 8;
   localparam int FLT_DIV32 = 32;
   localparam int FLT_DIV64 = 64;
   localparam int FLT_CNT_W = 6;
   localparam int FLT_SAMPLES = 3;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic analog_input_select; // bit 9
      logic interrupt_input_select; // bit 8
      logic pin_output_latch; // bit 7 output latch
      logic pin_direction_bit; // bit 6 direction, 1 = output
      logic peripheral_mode_bit; // bit 5 peripheral mode
      logic [4:0] psel; // bits 4:0
   } pfi_pfs_t;
   typedef struct packed {
      logic noise_filter_enable; // bit 4
      logic [1:0] fclk; // bits 3:2
      pfi_trig_t trig; // bits 1:0
   } pfi_icr_t;
   localparam pfi_pfs_t PFS_RST = '0;
   localparam pfi_icr_t ICR_RST = '0;
endpackage

// ### rtl/pfi_top.sv
// pfi_top: per-pin function select registers and external interrupt detection
// assumes a classic wishbone master on ref_clk and asynchronous pad inputs
// Summary of operation
// R01: every pin owns its own function select register.
// R02: each select register holds peripheral select, interrupt select and analog select.
// R03: software keeps analog pins in general-purpose input mode.
// R04: software clears peripheral mode before rewriting a select register.
// R05: select register writes are ignored until the write protection register enables them.
// R06: software never maps one peripheral function to several pins.
// R07: deep-standby interrupt pins raise a wake request.
// R08: normal and deep-standby pins of one number share one interrupt line.
// R09: interrupt select bit set connects the pin to its interrupt input.
// R10: interrupt select and peripheral selection may be active together.
// R11: software enables each interrupt number on one pin only.
// R12: each interrupt detects low level, falling, rising or both edges.
// R13: filter samples at clock, clock/8, clock/32 or clock/64.
// R14: pulses shorter than three samples are suppressed when filtering.
// R15: enabled filter delays detection by the filter time.
// R16: each interrupt has its own filter enable bit.
// R17: each interrupt has its own two-bit filter rate field.
// R18: software drives unbonded pins as low outputs.
// R19: peripheral mode bits reset to zero, general-purpose operation.
// R20: direction bit one means output; direction resets to input.
// R21: filter output moves only after three equal consecutive samples.
// R22: pin inputs are synchronised before filtering or edge detection.
`timescale 1ns/10ps
module pfi_top (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pfi_pkg::AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [pfi_pkg::DW-1:0] wb_dat_i,
   output logic [pfi_pkg::DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [pfi_pkg::NPINS-1:0] pad_in,
   output logic [pfi_pkg::NPINS-1:0] pad_out,
   output logic [pfi_pkg::NPINS-1:0] pad_oe,
   input wire logic [pfi_pkg::NPINS-1:0] periph_out,
   input wire logic [pfi_pkg::NPINS-1:0] periph_oe,
   output logic [pfi_pkg::NPINS-1:0] periph_in,
   output logic [pfi_pkg::NPINS*5-1:0] periph_sel,
   output logic [pfi_pkg::NPINS-1:0] analog_en,
   output logic [pfi_pkg::NIRQ-1:0] irq_req,
   output logic deep_standby_wake
);
   // ----------------------------------------
   // address decode helpers
   // ----------------------------------------
   // index of a word in a bank, or -1 when outside it
   function automatic int bank_idx(input logic [pfi_pkg::AW-1:0] adr, input logic [pfi_pkg::AW-1:0] base,
                                   input int n);
      int off;
      off = int'(adr) - int'(base);
      if (off >= 0 && off < 4 * n && off[1:0] == 2'h0) begin
         return off / 4;
      end
      return -1;
   endfunction

   // byte-lane merge of a write into a stored field
   function automatic logic [pfi_pkg::DW-1:0] lane_merge(input logic [pfi_pkg::DW-1:0] old,
                                                          input logic [pfi_pkg::DW-1:0] wdat,
                                                          input logic [3:0] sel);
      logic [pfi_pkg::DW-1:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (wdat & m);
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   pfi_pkg::pfi_pfs_t pfs_reg [pfi_pkg::NPINS];
   pfi_pkg::pfi_pfs_t pfs_next [pfi_pkg::NPINS];
   pfi_pkg::pfi_icr_t icr_reg [pfi_pkg::NIRQ];
   pfi_pkg::pfi_icr_t icr_next [pfi_pkg::NIRQ];
   logic wpr_reg, wpr_next;
   logic ack_reg, ack_next;
   logic [pfi_pkg::DW-1:0] rdat_reg, rdat_next;
   logic [pfi_pkg::NPINS-1:0] sync1_reg, sync2_reg;
   logic [pfi_pkg::NPINS-1:0] pin_in_reg, pin_in_next;
   logic [pfi_pkg::NIRQ-1:0] prev_reg, prev_next;
   logic [pfi_pkg::NIRQ-1:0] irq_reg, irq_next;
   logic wake_reg, wake_next;
   logic [pfi_pkg::NIRQ-1:0] irq_src, irq_lvl;
   logic wr_stb, rd_stb;
   int widx_pfs, widx_icr;

   // ----------------------------------------
   // pad input synchroniser
   // ----------------------------------------
   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else if (ce) begin
         sync1_reg <= pad_in; // [R22]
         sync2_reg <= sync1_reg; // [R22]
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   // ack one cycle after the request; write commits on the acked edge
   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
      rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg;
      widx_pfs = bank_idx(wb_adr_i, pfi_pkg::ADR_PFS_BASE, pfi_pkg::NPINS);
      widx_icr = bank_idx(wb_adr_i, pfi_pkg::ADR_ICR_BASE, pfi_pkg::NIRQ);
   end

   // register writes; select registers are locked while the write enable bit is clear
   always_comb begin
      logic [pfi_pkg::DW-1:0] tmp;
      tmp = '0;
      wpr_next = wpr_reg;
      pfs_next = pfs_reg;
      icr_next = icr_reg;
      if (wr_stb) begin
         if (wb_adr_i == pfi_pkg::ADR_WPR && wb_sel_i[0]) begin
            wpr_next = wb_dat_i[pfi_pkg::WPR_WE_BIT];
         end
         if (widx_pfs >= 0 && wpr_reg) begin
            tmp = lane_merge(pfi_pkg::DW'(pfs_reg[widx_pfs]), wb_dat_i, wb_sel_i);
            pfs_next[widx_pfs] = pfi_pkg::pfi_pfs_t'(tmp[pfi_pkg::PFS_W-1:0]); // [R01] [R05]
         end
         if (widx_icr >= 0) begin
            tmp = lane_merge(pfi_pkg::DW'(icr_reg[widx_icr]), wb_dat_i, wb_sel_i);
            icr_next[widx_icr] = pfi_pkg::pfi_icr_t'(tmp[pfi_pkg::ICR_W-1:0]); // [R12] [R16] [R17]
         end
      end
   end

   // read mux; unmapped words read as zero and are still acked
   always_comb begin
      rdat_next = rdat_reg;
      if (rd_stb) begin
         rdat_next = '0;
         if (wb_adr_i == pfi_pkg::ADR_WPR) begin
            rdat_next[pfi_pkg::WPR_WE_BIT] = wpr_reg;
         end else if (wb_adr_i == pfi_pkg::ADR_LEVEL) begin
            rdat_next = pfi_pkg::DW'(irq_lvl);
         end else if (wb_adr_i == pfi_pkg::ADR_PIN_IN) begin
            rdat_next = pfi_pkg::DW'(pin_in_reg);
         end else if (widx_pfs >= 0) begin
            rdat_next = pfi_pkg::DW'(pfs_reg[widx_pfs]); // [R02]
         end else if (widx_icr >= 0) begin
            rdat_next = pfi_pkg::DW'(icr_reg[widx_icr]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wpr_reg <= 1'b0; // [R05]
         ack_reg <= 1'b0;
         rdat_reg <= '0;
         for (int p = 0; p < pfi_pkg::NPINS; p++) begin
            pfs_reg[p] <= pfi_pkg::PFS_RST; // [R19] [R20]
         end
         for (int i = 0; i < pfi_pkg::NIRQ; i++) begin
            icr_reg[i] <= pfi_pkg::ICR_RST;
         end
      end else if (ce) begin
         wpr_reg <= wpr_next;
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         pfs_reg <= pfs_next;
         icr_reg <= icr_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ----------------------------------------
   // pin function routing
   // ----------------------------------------
   // peripheral path and interrupt path are independent, so both may run
   generate
      for (genvar p = 0; p < pfi_pkg::NPINS; p++) begin : g_pin
         assign pad_out[p] = pfs_reg[p].peripheral_mode_bit ? periph_out[p] : pfs_reg[p].pin_output_latch; // [R19]
         assign pad_oe[p] = pfs_reg[p].peripheral_mode_bit ? periph_oe[p] : pfs_reg[p].pin_direction_bit; // [R20]
         assign periph_in[p] = pin_in_reg[p] & pfs_reg[p].peripheral_mode_bit; // [R10]
         assign periph_sel[p*5 +: 5] = pfs_reg[p].psel; // [R02]
         assign analog_en[p] = pfs_reg[p].analog_input_select; // [R02]
      end
   endgenerate

   // unselected pins idle high so a low-level trigger never fires on them
   always_comb begin
      pin_in_next = sync2_reg;
      for (int i = 0; i < pfi_pkg::NIRQ; i++) begin
         irq_src[i] = (pfs_reg[i].interrupt_input_select ? sync2_reg[i] : 1'b1) // [R09]
                    & (pfs_reg[i+pfi_pkg::NIRQ].interrupt_input_select ? sync2_reg[i+pfi_pkg::NIRQ] : 1'b1); // [R08]
      end
   end

   // ----------------------------------------
   // noise filters
   // ----------------------------------------
   generate
      for (genvar i = 0; i < pfi_pkg::NIRQ; i++) begin : g_flt
         pfi_filter u_flt (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .ce(ce),
            .din(irq_src[i]),
            .en(icr_reg[i].noise_filter_enable), // [R16]
            .fclk(icr_reg[i].fclk), // [R17]
            .dout(irq_lvl[i])
         );
      end
   endgenerate

   // ----------------------------------------
   // trigger detection
   // ----------------------------------------
   // edge modes give a one-cycle pulse, low level holds while low
   always_comb begin
      prev_next = irq_lvl;
      wake_next = 1'b0;
      for (int i = 0; i < pfi_pkg::NIRQ; i++) begin
         case (icr_reg[i].trig)
            pfi_pkg::PFI_TRIG_LOW: irq_next[i] = ~irq_lvl[i]; // [R12]
            pfi_pkg::PFI_TRIG_FALL: irq_next[i] = prev_reg[i] & ~irq_lvl[i]; // [R12]
            pfi_pkg::PFI_TRIG_RISE: irq_next[i] = ~prev_reg[i] & irq_lvl[i]; // [R12]
            pfi_pkg::PFI_TRIG_BOTH: irq_next[i] = prev_reg[i] ^ irq_lvl[i]; // [R12]
            default: irq_next[i] = 1'b0;
         endcase
         if (irq_next[i] && pfs_reg[i+pfi_pkg::NIRQ].interrupt_input_select) begin
            wake_next = 1'b1; // [R07]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pin_in_reg <= '0;
         prev_reg <= '1;
         irq_reg <= '0;
         wake_reg <= 1'b0;
      end else if (ce) begin
         pin_in_reg <= pin_in_next;
         prev_reg <= prev_next;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
      end
   end

   assign irq_req = irq_reg;
   assign deep_standby_wake = wake_reg;
endmodule

// ### verification/pfi_pad_model.sv
// pfi_pad_model: board pads and peripheral drive facing pfi_top
// assumes the bench requests pad levels on lvl; pads idle high
`timescale 1ns/10ps
module pfi_pad_model (
   input wire logic ref_clk,
   input wire logic [pfi_pkg::NPINS-1:0] lvl,
   output logic [pfi_pkg::NPINS-1:0] pad_in,
   output logic [pfi_pkg::NPINS-1:0] periph_out,
   output logic [pfi_pkg::NPINS-1:0] periph_oe
);
   logic [pfi_pkg::NPINS-1:0] pad_q = 8'hff;
   logic [pfi_pkg::NPINS-1:0] per_q = 8'h5a;
   assign periph_oe = 8'h0f;
   assign pad_in = pad_q;
   assign periph_out = per_q;
   // pads follow requests one edge late; peripheral data toggles so a stale mux shows
   always @(posedge ref_clk) begin
      pad_q <= lvl;
      per_q <= ~per_q;
   end
endmodule

// ### verification/pfi_top_chk.sv
// pfi_top_chk: bus handshake, lock and sync-path assertions on pfi_top ports
// assumes ce stays high whenever the bus or the pads are exercised
`timescale 1ns/10ps
module pfi_top_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pfi_pkg::AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [pfi_pkg::DW-1:0] wb_dat_i,
   input wire logic [pfi_pkg::DW-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [pfi_pkg::NPINS-1:0] pad_in,
   input wire logic [pfi_pkg::NPINS-1:0] periph_in,
   input wire logic [pfi_pkg::NPINS*5-1:0] periph_sel,
   input wire logic [pfi_pkg::NPINS-1:0] analog_en,
   input wire logic [pfi_pkg::NIRQ-1:0] irq_req,
   input wire logic deep_standby_wake
);
   // ----
   // shadow of the write enable bit, taken from completed bus writes
   // ----
   logic unlock_reg;
   logic unlock_next;
   always_comb begin
      unlock_next = unlock_reg;
      if (wb_ack_o && wb_we_i && wb_adr_i == pfi_pkg::ADR_WPR && wb_sel_i[0]) begin
         unlock_next = wb_dat_i[pfi_pkg::WPR_WE_BIT];
      end
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         unlock_reg <= 1'b0;
      end else begin
         unlock_reg <= unlock_next;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // select outputs only move after an acked write while unlocked
   chk_pfs_locked: assert property (!$stable({periph_sel, analog_en}) |-> $past(wb_ack_o && wb_we_i && unlock_reg))
      else $error("select register changed while locked");
   chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##1 wb_ack_o)
      else $error("ack not two edges after request");
   chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c |-> wb_dat_o == '0)
      else $error("unmapped read not zero");
   chk_sync_depth: assert property ((periph_in & ~$past(pad_in, 3)) == '0)
      else $error("peripheral input ahead of sync chain");
   chk_wake_irq: assert property (deep_standby_wake |-> irq_req != '0)
      else $error("wake without interrupt event");
   chk_reset_idle: assert property ($rose(nrst) |-> !wb_ack_o && irq_req == '0 && !deep_standby_wake)
      else $error("outputs active after reset");
endmodule
bind pfi_top pfi_top_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .pad_in(pad_in), .periph_in(periph_in), .periph_sel(periph_sel),
   .analog_en(analog_en), .irq_req(irq_req), .deep_standby_wake(deep_standby_wake));

// ### verification/test_pin_function_irq_filter.sv
// test_pin_function_irq_filter: register, trigger, filter and wake tests for pfi_top
// assumes pfi_pad_model on the pads and ce held high
`timescale 1ns/10ps
module test_pin_function_irq_filter;
   logic ref_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = '0, lvl = 8'hff, pad_in, pad_out, pad_oe, p_out, p_oe, p_in, analog_en;
   logic [3:0] sel = '0, irq_req;
   logic [31:0] wdat = '0, rd, wb_dat_o;
   logic [39:0] periph_sel;
   logic wb_ack_o, wake;
   int err_total = 0, n_tests = 0, irq_n = 0, wake_n = 0;
   int divs[4] = '{1, 8, 32, 64};
   int trig_exp[4] = '{5, 1, 1, 2};
   initial forever #4 ref_clk = ~ref_clk;
   pfi_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
      .periph_sel(periph_sel), .analog_en(analog_en), .irq_req(irq_req), .deep_standby_wake(wake));
   pfi_pad_model pad_u (.ref_clk(ref_clk), .lvl(lvl), .pad_in(pad_in), .periph_out(p_out), .periph_oe(p_oe));
   // ----
   // shared tasks
   // ----
   always @(posedge ref_clk) begin
      if (irq_req[0] === 1'b1) irq_n++;
      if (wake === 1'b1) wake_n++;
   end
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one classic cycle; request held until ack is seen at an edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (n >= 40) chk("ack", 1, 0);
      rd = wb_dat_o;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge ref_clk);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   // low pulse on one pad, long settle so slow filter rates finish
   task pulse(input int p, input int len, input int e_irq, input int e_wake);
      irq_n = 0;
      wake_n = 0;
      lvl[p] <= 0;
      repeat (len) @(posedge ref_clk);
      lvl[p] <= 1;
      repeat (2 * len + 60) @(posedge ref_clk);
      chk("irq cycles", e_irq, irq_n);
      chk("wake cycles", e_wake, wake_n);
   endtask
   initial begin
      #200000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      rdc("pfs0 reset", 8'h40, 0);
      rdc("icr0 reset", 8'h20, 0);
      chk("pad_oe reset", 0, pad_oe);
      xfer(1, 8'h40, 32'h3ff);
      rdc("pfs0 locked", 8'h40, 0);
      xfer(1, 8'h0c, 32'hffffffff);
      rdc("unmapped", 8'h0c, 0);
      xfer(1, 8'h00, 32'h1);
      for (int p = 0; p < 8; p++) xfer(1, 8'h40 + 8'(4 * p), (p % 2 ? 32'h200 : 32'h0c0) | (p + 1));
      for (int p = 0; p < 8; p++) begin
         rdc("pfs", 8'h40 + 8'(4 * p), (p % 2 ? 32'h200 : 32'h0c0) | (p + 1));
         chk("periph_sel", p + 1, periph_sel[5 * p +: 5]);
         chk("analog_en", p % 2, analog_en[p]);
         chk("pad_oe", 1 - p % 2, pad_oe[p]);
         chk("pad_out", 1 - p % 2, pad_out[p]);
         xfer(1, 8'h40 + 8'(4 * p), 32'h0);
      end
      $display("test registers done");
      // trigger modes with the filter off; software keeps only pin 0 on irq 0
      xfer(1, 8'h40, 32'h100);
      for (int m = 0; m < 4; m++) begin
         xfer(1, 8'h20, m);
         pulse(0, 5, trig_exp[m], 0);
      end
      $display("test trigger done");
      for (int r = 0; r < 4; r++) begin
         xfer(1, 8'h20, 32'h11 | r << 2);
         pulse(0, 2 * divs[r], 0, 0);
         pulse(0, 3 * divs[r], 1, 0);
      end
      $display("test filter done");
      xfer(1, 8'h20, 32'h1);
      xfer(1, 8'h40, 32'h0);
      pulse(0, 5, 0, 0);
      xfer(1, 8'h50, 32'h100);
      pulse(4, 5, 1, 1);
      xfer(1, 8'h50, 32'h0);
      $display("test wake done");
      // pin 7 treated as unbonded: low output
      xfer(1, 8'h5c, 32'h040);
      chk("pad_oe7", 1, pad_oe[7]);
      chk("pad_out7", 0, pad_out[7]);
      xfer(1, 8'h40, 32'h125);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("periph_sel0", 5, periph_sel[4:0]);
      chk("pad_out0", p_out[0], pad_out[0]);
      chk("pad_oe0", p_oe[0], pad_oe[0]);
      chk("periph_in0", 1, p_in[0]);
      @(posedge ref_clk);
      pulse(0, 5, 1, 0);
      $display("test shared pin done");
      tally_and_finish;
   end
endmodule
